/* File: bench/dkp_core_model.sv */
// drive power core model facing the panel
`timescale 1ns/100ps
module dkp_core_model (
  input  wire        mclk,       // clock
  input  wire        run_cmd,    // run request
  output reg         gen_active, // output on
  output wire [15:0] load_val,   // load
  output wire [15:0] volt_val    // volts
);
  // ==========
  // core
  // values stay live while stopped, so the panel must blank them
  initial gen_active = 1'b0;
  always @(posedge mclk) begin
    gen_active <= run_cmd;
  end
  assign load_val = 16'h0042;
  assign volt_val = 16'h00e6;
endmodule

/* File: bench/dkp_panel_monitor.sv */
// assertion checker for the keypad panel
`timescale 1ns/100ps
module dkp_panel_chk (
  input wire        mclk,                  // clock
  input wire        rstn,                  // reset
  input wire        power_ok,              // power
  input wire        trip_fault,            // trip
  input wire        fault_cause_gone,      // cause gone
  input wire        gen_active,            // output on
  input wire        remote_enable_setting, // remote
  input wire        ext_ref_present,       // ref connected
  input wire        ref_input_jumper,      // jumper set
  input wire        remote_display_enable, // remref display on
  input wire        forward_only_setting,  // fwd only
  input wire        run_cmd,               // run
  input wire        coast_cmd,             // coast
  input wire        fault_clear,           // clear
  input wire        dir_rev,               // reverse
  input wire [1:0]  disp_mode,             // mode
  input wire [2:0]  disp_src,              // source
  input wire [15:0] disp_val,              // value
  input wire        prog_mode,             // program
  input wire [7:0]  led                    // leds
);
  // ==========
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_run_led; $past(rstn) |-> led[7] == $past(gen_active); endproperty
  a_run_led: assert property (p_run_led) else $error("run led");
  property p_prog_led; led[4] == $past(prog_mode); endproperty
  a_prog_led: assert property (p_prog_led) else $error("prog led");
  property p_rem_off; !remote_enable_setting [*3] |-> !led[3]; endproperty
  a_rem_off: assert property (p_rem_off) else $error("remote led");
  property p_remref;
    $past(disp_mode) == 2'h3 && $past(remote_enable_setting && ext_ref_present
      && ref_input_jumper && remote_display_enable) |-> led[3:0] == 4'hf;
  endproperty
  a_remref: assert property (p_remref) else $error("remref leds");
  property p_onehot; led[2:0] != 3'h0 |-> $onehot(led[2:0]) || led[3:0] == 4'hf; endproperty
  a_onehot: assert property (p_onehot) else $error("mode leds");
  property p_start; $rose(run_cmd) |-> $past(power_ok) && !$past(trip_fault); endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_trip; trip_fault && run_cmd |=> !run_cmd && coast_cmd; endproperty
  a_trip: assert property (p_trip) else $error("trip");
  property p_zero;
    disp_src inside {3'h1, 3'h2} && !$past(run_cmd) |-> disp_val == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("stopped value");
  property p_clear; fault_clear |-> $past(fault_cause_gone) && !run_cmd; endproperty
  a_clear: assert property (p_clear) else $error("clear");
  property p_dir;
    $rose(dir_rev) |-> !$past(remote_enable_setting) && !$past(forward_only_setting);
  endproperty
  a_dir: assert property (p_dir) else $error("dir");
endmodule

bind dkp_panel dkp_panel_chk u_chk (
  .mclk(mclk), .rstn(rstn), .power_ok(power_ok), .trip_fault(trip_fault),
  .fault_cause_gone(fault_cause_gone), .gen_active(gen_active),
  .remote_enable_setting(remote_enable_setting), .forward_only_setting(forward_only_setting),
  .ext_ref_present(ext_ref_present), .ref_input_jumper(ref_input_jumper),
  .remote_display_enable(remote_display_enable),
  .run_cmd(run_cmd), .coast_cmd(coast_cmd), .fault_clear(fault_clear), .dir_rev(dir_rev),
  .disp_mode(disp_mode), .disp_src(disp_src), .disp_val(disp_val), .prog_mode(prog_mode),
  .led(led));

/* File: bench/tb_top.sv */
// self-checking bench for the keypad panel
`timescale 1ns/100ps
module tb_top;
  localparam DEB = 4;
  reg         mclk = 1'b0;
  reg         rstn = 1'b0;
  reg  [5:0]  key_raw = 6'h00;
  reg         power_ok = 1'b1;
  reg         trip_fault = 1'b0;
  reg         fault_cause_gone = 1'b0;
  reg         remote_enable_setting = 1'b0;
  reg  [2:0]  rref_en = 3'h0;
  reg         forward_only_setting = 1'b0;
  reg         stop_type_setting = 1'b0;
  reg  [1:0]  saved_disp_mode = 2'h0;
  reg         saved_valid = 1'b0;
  reg  [15:0] saved_speed_ref = 16'h0123;
  wire        run_cmd, coast_cmd, fault_clear, dir_rev, disp_flash, prog_mode, gen_active;
  wire        func_sel, func_save, func_inc, func_dec;
  wire [15:0] speed_ref, disp_val, load_val, volt_val;
  wire [1:0]  disp_mode;
  wire [2:0]  disp_src;
  wire [4:0]  func_num;
  wire [7:0]  led;
  integer     n_mismatch = 0, checks = 0, n_clr = 0, cyc = 0, k, stp = 0, n_fn = 0;
  logic [1:0] m_exp [7] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  dkp_panel #(.DEB_CYC(DEB), .HOLD_CYC(40), .SLOW_CYC(8), .FAST_CYC(2), .REVERT_CYC(20))
  u_dkp_panel (
    .mclk(mclk), .rstn(rstn), .key_raw(key_raw), .power_ok(power_ok),
    .trip_fault(trip_fault), .fault_code(8'h0a), .fault_cause_gone(fault_cause_gone),
    .gen_active(gen_active), .remote_enable_setting(remote_enable_setting),
    .ext_ref_present(rref_en[0]), .ref_input_jumper(rref_en[1]),
    .remote_display_enable(rref_en[2]), .forward_only_setting(forward_only_setting),
    .stop_type_setting(stop_type_setting), .ext_start(1'b0),
    .saved_disp_mode(saved_disp_mode), .saved_valid(saved_valid),
    .saved_speed_ref(saved_speed_ref), .speed_val(16'h0456), .load_val(load_val),
    .volt_val(volt_val), .remref_val(16'h0032), .func_val_in(16'h0007),
    .run_cmd(run_cmd), .coast_cmd(coast_cmd), .fault_clear(fault_clear), .dir_rev(dir_rev),
    .speed_ref(speed_ref), .disp_mode(disp_mode), .disp_src(disp_src), .disp_val(disp_val),
    .disp_flash(disp_flash), .prog_mode(prog_mode), .func_num(func_num),
    .func_sel(func_sel), .func_save(func_save), .func_inc(func_inc), .func_dec(func_dec),
    .led(led));
  dkp_core_model u_dkp_core_model (.mclk(mclk), .run_cmd(run_cmd), .gen_active(gen_active),
    .load_val(load_val), .volt_val(volt_val));
  // ==========
  // clock, pulse count, hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (fault_clear === 1'b1) n_clr = n_clr + 1;
    if (rstn) n_fn = n_fn + {func_save, func_inc, func_dec};
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end
  // ==========
  // helpers
  task wrap_up;
    begin
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  task press(input integer b);
    begin
      key_raw[b] = 1'b1;
      tick(DEB + 3);
      key_raw[b] = 1'b0;
      tick(DEB + 8);
    end
  endtask
  // ==========
  // scenarios
  task t_reset(input v, input [1:0] m);
    begin
      saved_valid = v;
      saved_disp_mode = m;
      rstn = 1'b0;
      tick(20);
      rstn = 1'b1;
      tick(DEB + 4);
      chk(disp_mode, v ? m : 2'h0);
      chk(speed_ref, saved_speed_ref);
    end
  endtask
  task t_start;
    begin
      power_ok = 1'b0;
      press(0);
      chk(run_cmd, 1'b0);
      power_ok = 1'b1;
      remote_enable_setting = 1'b1;
      press(0);
      chk(run_cmd, 1'b0);
      remote_enable_setting = 1'b0;
      press(0);
      chk(led, 8'ha1);
    end
  endtask
  task t_modes;
    begin
      for (k = 0; k < 7; k = k + 1) begin
        if (k == 3) begin
          remote_enable_setting = 1'b1;
          rref_en = 3'h7;
        end
        press(2);
        chk(disp_mode, m_exp[k]);
        if (k == 5) chk(led[3:0], 4'hf);
      end
    end
  endtask
  task t_arrows;
    begin
      key_raw[4] = 1'b1;
      tick(DEB + 3);
      key_raw[4] = 1'b0;
      tick(2);
      chk(disp_src, 3'h4);
      chk(disp_val, saved_speed_ref + 16'h0001);
      tick(DEB + 6);
      chk(speed_ref, saved_speed_ref + 16'h0001);
      tick(30);
      chk(disp_src, 3'h0);
      remote_enable_setting = 1'b0;
      rref_en = 3'h0;
      press(5);
      chk(speed_ref, saved_speed_ref);
      key_raw[5] = 1'b1;
      tick(DEB + 6);
      k = speed_ref;
      tick(16);
      k = k - speed_ref;
      tick(40);
      stp = speed_ref;
      tick(16);
      stp = stp - speed_ref;
      key_raw[5] = 1'b0;
      tick(DEB + 8);
      chk(stp > k, 1'b1);
    end
  endtask
  task t_dir;
    begin
      press(3);
      chk(led[6:5], 2'h2);
      press(3);
      forward_only_setting = 1'b1;
      press(3);
      chk({dir_rev, led[6]}, 2'h0);
      forward_only_setting = 1'b0;
    end
  endtask
  task t_stop;
    begin
      press(2);
      for (k = 0; k < 2; k = k + 1) begin
        stop_type_setting = k[0];
        remote_enable_setting = k[0];
        press(1);
        chk({run_cmd, coast_cmd}, {1'b0, k[0]});
        chk(disp_val, 16'h0000);
        remote_enable_setting = 1'b0;
        if (k == 0) press(0);
      end
    end
  endtask
  task t_fault;
    begin
      press(0);
      trip_fault = 1'b1;
      tick(3);
      chk({run_cmd, coast_cmd, disp_flash, disp_src}, {3'h3, 3'h5});
      chk(disp_val, 16'h000a);
      trip_fault = 1'b0;
      press(0);
      chk(run_cmd, 1'b0);
      fault_cause_gone = 1'b1;
      press(1);
      chk(n_clr, 16'h0001);
    end
  endtask
  task t_prog;
    begin
      press(2);
      chk({prog_mode, led[4]}, 2'h3);
      press(4);
      chk(func_num, 5'h01);
      press(5);
      chk(func_num, 5'h00);
      press(2);
      chk(func_sel, 1'b1);
      chk(disp_val, 16'h0007);
      press(4);
      press(5);
      press(2);
      chk(func_sel, 1'b0);
      chk(n_fn, 16'h0007);
      press(1);
      chk(prog_mode, 1'b0);
    end
  endtask
  initial begin
    t_reset(1'b1, 2'h2);
    t_reset(1'b0, 2'h1);
    t_start;
    t_modes;
    t_arrows;
    t_dir;
    t_stop;
    t_fault;
    t_prog;
    wrap_up;
  end
endmodule

/* File: rtl/dkp_consts.vh */
// constants for the drive keypad panel control block
`ifndef DKP_CONSTS_VH
`define DKP_CONSTS_VH

// timing, at 100 MHz
`define DKP_CLK_HZ          100000000
`define DKP_DEB_MS          10
`define DKP_DEB_CYC         ((`DKP_CLK_HZ / 1000) * `DKP_DEB_MS)
`define DKP_HOLD_MS         3000
`define DKP_HOLD_CYC        ((`DKP_CLK_HZ / 1000) * `DKP_HOLD_MS)
`define DKP_SLOW_MS         400
`define DKP_SLOW_CYC        ((`DKP_CLK_HZ / 1000) * `DKP_SLOW_MS)
`define DKP_FAST_MS         80
`define DKP_FAST_CYC        ((`DKP_CLK_HZ / 1000) * `DKP_FAST_MS)
`define DKP_REVERT_MS       2000
`define DKP_REVERT_CYC      ((`DKP_CLK_HZ / 1000) * `DKP_REVERT_MS)

// display mode codes
`define DKP_DM_SPEED        2'h0
`define DKP_DM_LOAD         2'h1
`define DKP_DM_VOLT         2'h2
`define DKP_DM_REMREF       2'h3

// display source select
`define DKP_SRC_SPEED       3'h0
`define DKP_SRC_LOAD        3'h1
`define DKP_SRC_VOLT        3'h2
`define DKP_SRC_REMREF      3'h3
`define DKP_SRC_HZREF       3'h4
`define DKP_SRC_FAULT       3'h5
`define DKP_SRC_FUNC        3'h6

// program navigation and speed reference
`define DKP_FUNC_LAST       5'h13
`define DKP_SPEED_MAX       16'hffff
`define DKP_SPEED_RST       16'h0000

`endif

/* File: rtl/dkp_panel.v */
// keypad and indicator control for the drive front panel
`timescale 1ns/100ps
`include "dkp_consts.vh"

module dkp_panel #(
  parameter DEB_CYC    = `DKP_DEB_CYC,
  parameter HOLD_CYC   = `DKP_HOLD_CYC,
  parameter SLOW_CYC   = `DKP_SLOW_CYC,
  parameter FAST_CYC   = `DKP_FAST_CYC,
  parameter REVERT_CYC = `DKP_REVERT_CYC
) (
  input  wire        mclk,                  // system clock
  input  wire        rstn,                  // sync reset, active low
  input  wire [5:0]  key_raw,               // start,stop,mode,dir,up,down; high pressed
  input  wire        power_ok,              // drive power applied
  input  wire        trip_fault,            // trip fault level from power core
  input  wire [7:0]  fault_code,            // fault type code to flash
  input  wire        fault_cause_gone,      // fault cause removed
  input  wire        gen_active,            // core is generating output
  input  wire        remote_enable_setting, // remote control selected
  input  wire        ext_ref_present,       // external reference connected
  input  wire        ref_input_jumper,      // reference jumper set correctly
  input  wire        remote_display_enable, // remote reference display enabled
  input  wire        forward_only_setting,  // rotation forced forward
  input  wire        stop_type_setting,     // 1 coast, 0 ramp
  input  wire        ext_start,             // terminal strip start pulse
  input  wire [1:0]  saved_disp_mode,       // display mode held over power-down
  input  wire        saved_valid,           // saved mode is valid
  input  wire [15:0] saved_speed_ref,       // setpoint held over power-down
  input  wire [15:0] speed_val,             // speed value
  input  wire [15:0] load_val,              // percent load value
  input  wire [15:0] volt_val,              // output voltage value
  input  wire [15:0] remref_val,            // external ref percent value
  input  wire [15:0] func_val_in,           // value of selected function
  output reg         run_cmd,               // drive run request
  output reg         coast_cmd,             // coast rather than ramp
  output reg         fault_clear,           // fault clear pulse
  output reg         dir_rev,               // requested reverse rotation
  output reg  [15:0] speed_ref,             // internal speed reference
  output reg  [1:0]  disp_mode,             // active display mode
  output reg  [2:0]  disp_src,              // what the display shows
  output reg  [15:0] disp_val,              // displayed value
  output reg         disp_flash,            // display flashing
  output reg         prog_mode,             // program mode active
  output reg  [4:0]  func_num,              // selected function number
  output reg         func_sel,              // a function is opened
  output reg         func_save,             // save function value pulse
  output reg         func_inc,              // step function value up pulse
  output reg         func_dec,              // step function value down pulse
  output reg  [7:0]  led                    // speed,load,volt,remote,prog,fwd,rev,run
);

  // ===========================================================================
  // key conditioning
  reg  [5:0]  ks1_r, ks2_r, kprev_r;
  wire [5:0]  kst_r;
  wire [5:0]  kpress = kst_r & ~kprev_r;
  genvar      gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_deb
      reg [23:0] cnt_r;
      reg        bit_r;
      assign kst_r[gi] = bit_r;
      always @(posedge mclk) begin
        if (!rstn) begin
          cnt_r  <= 24'h00_0000;
          bit_r  <= 1'b0;
        end else if (ks2_r[gi] == bit_r) begin
          cnt_r  <= 24'h00_0000;
        end else if (cnt_r >= DEB_CYC[23:0] - 24'h00_0001) begin
          cnt_r  <= 24'h00_0000;
          bit_r  <= ks2_r[gi];
        end else begin
          cnt_r  <= cnt_r + 24'h00_0001;
        end
      end
    end
  endgenerate

  always @(posedge mclk) begin
    if (!rstn) begin
      ks1_r   <= 6'h00;
      ks2_r   <= 6'h00;
      kprev_r <= 6'h00;
    end else begin
      ks1_r   <= key_raw;
      ks2_r   <= ks1_r;
      kprev_r <= kst_r;
    end
  end

  wire k_start = kpress[0];
  wire k_stop  = kpress[1];
  wire k_mode  = kpress[2];
  wire k_dir   = kpress[3];

  // ===========================================================================
  // arrow auto-repeat
  reg  [28:0] hold_r, rep_r;
  wire        arrow_held = kst_r[4] ^ kst_r[5];
  wire        fast       = hold_r >= HOLD_CYC[28:0];
  wire [28:0] rep_max    = fast ? FAST_CYC[28:0] : SLOW_CYC[28:0];
  wire        rep_tick   = arrow_held && (rep_r >= rep_max - 29'h0000_0001);
  wire        step_up    = kpress[4] | (rep_tick & kst_r[4]);
  wire        step_dn    = kpress[5] | (rep_tick & kst_r[5]);

  always @(posedge mclk) begin
    if (!rstn || !arrow_held) begin
      hold_r <= 29'h0000_0000;
      rep_r  <= 29'h0000_0000;
    end else begin
      if (!fast)
        hold_r <= hold_r + 29'h0000_0001;
      rep_r <= rep_tick ? 29'h0000_0000 : rep_r + 29'h0000_0001;
    end
  end

  // ===========================================================================
  // run / fault / direction control
  localparam ST_IDLE  = 3'b001;
  localparam ST_RUN   = 3'b010;
  localparam ST_FAULT = 3'b100;
  reg  [2:0]  st_r;
  reg         loaded_r;
  wire        remote    = remote_enable_setting;
  wire        remref_ok = remote & ext_ref_present & ref_input_jumper
                        & remote_display_enable;

  always @(posedge mclk) begin
    if (!rstn) begin
      st_r        <= ST_IDLE;
      run_cmd     <= 1'b0;
      coast_cmd   <= 1'b0;
      fault_clear <= 1'b0;
    end else begin
      fault_clear <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (trip_fault) begin
            st_r      <= ST_FAULT;
            coast_cmd <= 1'b1;
          end else if (!prog_mode && power_ok
                       && ((k_start && !remote) || (ext_start && remote))) begin
            st_r      <= ST_RUN;
            run_cmd   <= 1'b1;
            coast_cmd <= 1'b0;
          end
        end
        ST_RUN: begin
          if (trip_fault) begin
            st_r      <= ST_FAULT;
            run_cmd   <= 1'b0;
            coast_cmd <= 1'b1;
          end else if (k_stop) begin
            st_r      <= ST_IDLE;
            run_cmd   <= 1'b0;
            coast_cmd <= stop_type_setting;
          end
        end
        ST_FAULT: begin
          run_cmd <= 1'b0;
          if (k_stop && fault_cause_gone) begin
            st_r        <= ST_IDLE;
            fault_clear <= 1'b1;
            coast_cmd   <= 1'b0;
          end
        end
        default: begin
          st_r    <= ST_IDLE;
          run_cmd <= 1'b0;
        end
      endcase
    end
  end

  wire running = st_r[1];

  always @(posedge mclk) begin
    if (!rstn)
      dir_rev <= 1'b0;
    else if (forward_only_setting)
      dir_rev <= 1'b0;
    else if (k_dir && !remote && !prog_mode)
      dir_rev <= ~dir_rev;
  end

  // ===========================================================================
  // display mode, program mode, speed reference
  // wide enough for the default revert delay
  reg [27:0] revert_r;

  always @(posedge mclk) begin
    if (!rstn) begin
      loaded_r  <= 1'b0;
      disp_mode <= `DKP_DM_SPEED;
      speed_ref <= `DKP_SPEED_RST;
      prog_mode <= 1'b0;
      func_num  <= 5'h00;
      func_sel  <= 1'b0;
      func_save <= 1'b0;
      func_inc  <= 1'b0;
      func_dec  <= 1'b0;
      revert_r  <= 28'h000_0000;
    end else begin
      func_save <= 1'b0;
      func_inc  <= 1'b0;
      func_dec  <= 1'b0;
      if (!loaded_r) begin
        loaded_r  <= 1'b1;
        disp_mode <= saved_valid ? saved_disp_mode : `DKP_DM_SPEED;
        speed_ref <= saved_speed_ref;
      end else if (prog_mode) begin
        if (k_stop || running) begin
          prog_mode <= 1'b0;
          func_sel  <= 1'b0;
        end else if (k_mode) begin
          func_sel  <= ~func_sel;
          func_save <= func_sel;
        end else if (func_sel) begin
          func_inc <= step_up;
          func_dec <= step_dn;
        end else if (step_up && func_num != `DKP_FUNC_LAST) begin
          func_num <= func_num + 5'h01;
        end else if (step_dn && func_num != 5'h00) begin
          func_num <= func_num - 5'h01;
        end
      end else if (k_mode && !running && st_r[0]) begin
        prog_mode <= 1'b1;
        func_num  <= 5'h00;
      end else begin
        if (k_mode && running) begin
          if (disp_mode == `DKP_DM_VOLT)
            disp_mode <= remref_ok ? `DKP_DM_REMREF : `DKP_DM_SPEED;
          else if (disp_mode == `DKP_DM_REMREF)
            disp_mode <= `DKP_DM_SPEED;
          else
            disp_mode <= disp_mode + 2'h1;
        end else if (disp_mode == `DKP_DM_REMREF && !remref_ok) begin
          disp_mode <= `DKP_DM_SPEED;
        end
        if (running && step_up && speed_ref != `DKP_SPEED_MAX)
          speed_ref <= speed_ref + 16'h0001;
        else if (running && step_dn && speed_ref != 16'h0000)
          speed_ref <= speed_ref - 16'h0001;
        if (running && remote && (step_up || step_dn))
          revert_r <= REVERT_CYC[27:0];
        else if (revert_r != 28'h000_0000)
          revert_r <= revert_r - 28'h000_0001;
      end
    end
  end

  // ===========================================================================
  // display mode decode
  // remote mode counts as speed while its enables are down
  wire [1:0]  mode_eff = (disp_mode == `DKP_DM_REMREF && !remref_ok) ?
                         `DKP_DM_SPEED : disp_mode;
  reg  [2:0]  mode_led;

  always @* begin
    case (mode_eff)
      `DKP_DM_SPEED: mode_led = 3'h1;
      `DKP_DM_LOAD:  mode_led = 3'h2;
      `DKP_DM_VOLT:  mode_led = 3'h4;
      default:       mode_led = 3'h7;
    endcase
  end

  // ===========================================================================
  // display value and LEDs
  always @(posedge mclk) begin
    if (!rstn) begin
      disp_src   <= `DKP_SRC_SPEED;
      disp_val   <= 16'h0000;
      disp_flash <= 1'b0;
      led        <= 8'h00;
    end else begin
      disp_flash <= st_r[2];
      if (st_r[2]) begin
        disp_src <= `DKP_SRC_FAULT;
        disp_val <= {8'h00, fault_code};
      end else if (prog_mode) begin
        disp_src <= `DKP_SRC_FUNC;
        disp_val <= func_sel ? func_val_in : {11'h000, func_num};
      end else if (revert_r != 28'h000_0000) begin
        disp_src <= `DKP_SRC_HZREF;
        disp_val <= speed_ref;
      end else begin
        case (mode_eff)
          `DKP_DM_LOAD: begin
            disp_src <= `DKP_SRC_LOAD;
            disp_val <= running ? load_val : 16'h0000;
          end
          `DKP_DM_VOLT: begin
            disp_src <= `DKP_SRC_VOLT;
            disp_val <= running ? volt_val : 16'h0000;
          end
          `DKP_DM_REMREF: begin
            disp_src <= `DKP_SRC_REMREF;
            disp_val <= remref_val;
          end
          default: begin
            disp_src <= `DKP_SRC_SPEED;
            disp_val <= running ? speed_val : 16'h0000;
          end
        endcase
      end
      led[2:0] <= mode_led;
      led[3] <= remote;
      led[4] <= prog_mode;
      led[5] <= gen_active && !dir_rev;
      led[6] <= gen_active && dir_rev && !forward_only_setting;
      led[7] <= gen_active;
    end
  end

endmodule
